// *** shared/mfs_pkg.sv ***
// Constants shared by the memory fault status block
package mfs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADR_W = 8;                       // Byte address width
    localparam int DAT_W = 32;                      // Data width

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;      // Fault flags, R/W1C
    localparam logic [7:0] OFS_IRQ_EN = 8'h04;      // Interrupt enable
    localparam logic [7:0] OFS_IRQ_CLR = 8'h08;     // Flag clear, write only
    localparam logic [7:0] OFS_FAULT_ADDR = 8'h0c;  // Captured fault address
    localparam logic [7:0] OFS_STACKED_PC = 8'h10;  // PC pushed for return
    localparam logic [7:0] OFS_CTRL = 8'h14;        // Protection unit control

    ////////////////////////////////////////////////////////////////////////////
    // Status field positions
    localparam int BIT_INSTR_VIOL = 0;              // Instruction access violation
    localparam int BIT_DATA_VIOL = 1;               // Data access violation
    localparam int BIT_RSVD = 2;                    // Reserved, reads zero
    localparam int BIT_UNSTACK_VIOL = 3;            // Unstack violation
    localparam int BIT_ADDR_VALID = 7;              // Fault address valid
    localparam int BIT_MPU_EN = 0;                  // Control: protection enable
    localparam int NUM_FLAGS = 4;                   // Sticky flags held
    localparam int STAT_W = 8;                      // Width of status layout

    ////////////////////////////////////////////////////////////////////////////
    // Flag index to status bit position
    localparam int FLAG_POS [NUM_FLAGS] = '{
        BIT_INSTR_VIOL, BIT_DATA_VIOL, BIT_UNSTACK_VIOL, BIT_ADDR_VALID
    };

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic RST_FLAG = 1'b0;               // Every flag clear
    localparam logic [7:0] RST_IRQ_EN = 8'h00;      // Interrupts disabled
    localparam logic RST_MPU_EN = 1'b0;             // Protection unit off
    localparam logic [31:0] RST_WORD = 32'h0000_0000;   // Address and PC
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;    // Unmapped read value

endpackage

// *** hdl/mfs_flag.sv ***
// Sticky event flag, cleared by software, set wins over clear
`timescale 1ns/1ps

module mfs_flag
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Event and clear
    input wire logic set_i,
    input wire logic clr_i,
    // Flag level
    output logic q_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic flag;                                 // Sticky flag
    } mfs_flag_st_t;

    mfs_flag_st_t cur_ff;                           // Registered state
    mfs_flag_st_t nxt_ff;                           // Next state

    // Set beats a clear in the same cycle, so no event is lost
    always_comb
    begin
        nxt_ff = cur_ff;
        if (set_i)
        begin
            nxt_ff.flag = 1'b1;                     // Event arrives
        end
        else if (clr_i)
        begin
            nxt_ff.flag = 1'b0;                     // Software clears
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cur_ff.flag <= mfs_pkg::RST_FLAG;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    assign q_o = cur_ff.flag;

endmodule

// *** hdl/mfs_wb_slave.sv ***
// Classic Wishbone slave handshake with registered acknowledge and read data
`timescale 1ns/1ps

module mfs_wb_slave
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus request
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    // Read data from decode
    input wire logic [31:0] rd_data_i,
    // Bus answer
    output logic ack_o,
    output logic [31:0] dat_o,
    // Write taken this cycle
    output logic wr_stb_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic ack;                                  // Acknowledge
        logic [31:0] dat;                           // Read data
    } mfs_wb_st_t;

    mfs_wb_st_t cur_ff;                             // Registered state
    mfs_wb_st_t nxt_ff;                             // Next state
    logic take;                                     // Request accepted

    // One answer per request; ack falls the cycle after it rose
    assign take = cyc_i & stb_i & ~cur_ff.ack;
    assign wr_stb_o = take & we_i;

    // Next state
    always_comb
    begin
        nxt_ff = cur_ff;
        nxt_ff.ack = take;
        if (take & ~we_i)
        begin
            nxt_ff.dat = rd_data_i;                 // Capture read word
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cur_ff.ack <= 1'b0;
            cur_ff.dat <= mfs_pkg::RST_WORD;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    assign ack_o = cur_ff.ack;
    assign dat_o = cur_ff.dat;

endmodule

// *** hdl/mfs_top.sv ***
// Memory fault status low bits: sticky flags, fault address, stacking control
//
// Operation
// - Unstack fault on return sets bit 3
// - Unstack fault chains to handler, frame kept
// - Unstack fault: SP held, no save, no address
// - Bit 2 reserved, read only, reads zero
// - Forbidden load or store sets bit 1
// - Data fault captures access address
// - Stacked PC points at faulting instruction
// - Fetch from non-executable location sets bit 0
// - Execute-never faults even without protection unit
// - Instruction fault leaves fault address untouched
// - Flags reset zero, write one clears
// - Address valid set only when address captured
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps

module mfs_top
(
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RESET_I,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Exception return unstacking
    input wire logic UNSTACK_FAULT_I,
    // Data access checking
    input wire logic DATA_FAULT_I,
    input wire logic [31:0] DATA_ADDR_I,
    // Instruction fetch checking
    input wire logic FETCH_ISSUE_I,
    input wire logic EXECUTE_NEVER_ATTRIBUTE_I,
    input wire logic FETCH_DENY_I,
    // Address of the instruction in flight
    input wire logic [31:0] FAULT_PC_I,
    // Exception sequencer control
    output logic FAULT_TAKE_O,
    output logic CHAIN_O,
    output logic SKIP_SAVE_O,
    output logic SP_HOLD_O,
    output logic STACK_PC_WE_O,
    output logic [31:0] STACK_PC_O,
    // Fault address register
    output logic [31:0] MEM_FAULT_ADDRESS_REG_O,
    // Interrupt
    output logic IRQ_O
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    // Block state apart from the flags and the bus handshake, in one packed struct
    typedef struct packed {
        logic [7:0] irq_en;                         // Interrupt enable
        logic mpu_en;                               // Protection unit enable
        logic [31:0] fault_addr;                    // Fault address register
        logic [31:0] stacked_pc;                    // PC to push on entry
        logic take;                                 // Enter fault handler
        logic chain;                                // Chained entry
        logic skip_save;                            // No new context save
        logic sp_hold;                              // Keep stack pointer
        logic pc_we;                                // Push stacked PC
        logic irq;                                  // Interrupt level
    } mfs_top_st_t;

    mfs_top_st_t cur_ff;                            // Registered state
    mfs_top_st_t nxt_ff;                            // Next state

    ////////////////////////////////////////////////////////////////////////////
    // Bus side signals
    logic wr_stb;                                   // Write taken this cycle
    logic [31:0] rd_data;                           // Decoded read word
    logic [31:0] wr_mask;                           // Byte enables as bit mask
    logic [31:0] wr_bits;                           // Write data under mask
    logic wr_status;                                // Write to status
    logic wr_clr;                                   // Write to clear register
    logic wr_en;                                    // Write to enable register
    logic wr_ctrl;                                  // Write to control

    ////////////////////////////////////////////////////////////////////////////
    // Fault side signals
    logic instr_viol;                               // Fetch violation now
    logic addr_capture;                             // Data fault that loads the address
    logic [mfs_pkg::NUM_FLAGS-1:0] flag_set;        // Per-flag set
    logic [mfs_pkg::NUM_FLAGS-1:0] flag_clr;        // Per-flag clear
    logic [mfs_pkg::NUM_FLAGS-1:0] flag_q;          // Per-flag level
    logic [7:0] status;                             // Assembled status byte

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake
    // Acknowledge comes one cycle after the request is taken
    mfs_wb_slave u_wb
    (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .cyc_i(WB_CYC_I),
        .stb_i(WB_STB_I),
        .we_i(WB_WE_I),
        .rd_data_i(rd_data),
        .ack_o(WB_ACK_O),
        .dat_o(WB_DAT_O),
        .wr_stb_o(wr_stb)
    );

    // Byte enables widened to a bit mask
    // Partial writes touch only the enabled byte lanes
    assign wr_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                      {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign wr_bits = WB_DAT_I & wr_mask;

    // Write decode; address is stable while the request stands
    // Full byte address compared, so no offset aliases another
    assign wr_status = wr_stb && (WB_ADR_I == mfs_pkg::OFS_STATUS);
    assign wr_clr = wr_stb && (WB_ADR_I == mfs_pkg::OFS_IRQ_CLR);
    assign wr_en = wr_stb && (WB_ADR_I == mfs_pkg::OFS_IRQ_EN);
    assign wr_ctrl = wr_stb && (WB_ADR_I == mfs_pkg::OFS_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // Fault detection
    // Execute-never faults regardless of protection unit state
    // A denied fetch faults only while the protection unit is on
    assign instr_viol = FETCH_ISSUE_I &
                        (EXECUTE_NEVER_ATTRIBUTE_I | (cur_ff.mpu_en & FETCH_DENY_I));

    // An unstack fault overrides a data fault in the same cycle and keeps
    // the address register, so that data fault must not mark it valid
    assign addr_capture = DATA_FAULT_I & ~UNSTACK_FAULT_I;

    // Set sources per flag, index order matches the package table
    assign flag_set[0] = instr_viol;
    assign flag_set[1] = DATA_FAULT_I;
    assign flag_set[2] = UNSTACK_FAULT_I;
    assign flag_set[3] = addr_capture;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags, one per flag bit of the status byte (bits 0, 1, 3, 7)
    generate
        for (genvar i = 0; i < mfs_pkg::NUM_FLAGS; i++)
        begin : g_flag
            // A fault in the clearing cycle still leaves the flag set
            // Write one to status or clear register clears; zero keeps
            assign flag_clr[i] = (wr_status | wr_clr) & wr_bits[mfs_pkg::FLAG_POS[i]];

            mfs_flag u_flag
            (
                .clk_i(MCLK_I),
                .rst_i(RESET_I),
                .set_i(flag_set[i]),
                .clr_i(flag_clr[i]),
                .q_o(flag_q[i])
            );
        end
    endgenerate

    // Status byte assembly; reserved bits tie to zero
    // Bits 6:4 have no flag behind them and read zero too
    always_comb
    begin
        status = 8'h00;
        status[mfs_pkg::BIT_INSTR_VIOL] = flag_q[0];
        status[mfs_pkg::BIT_DATA_VIOL] = flag_q[1];
        status[mfs_pkg::BIT_UNSTACK_VIOL] = flag_q[2];
        status[mfs_pkg::BIT_ADDR_VALID] = flag_q[3];
        status[mfs_pkg::BIT_RSVD] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped and write-only offsets read zero
    // The bus slave registers this word at the taking edge
    always_comb
    begin
        rd_data = mfs_pkg::RD_ZERO;
        unique case (WB_ADR_I)
            mfs_pkg::OFS_STATUS:
            begin
                rd_data[7:0] = status;
            end
            mfs_pkg::OFS_IRQ_EN:
            begin
                rd_data[7:0] = cur_ff.irq_en;
            end
            mfs_pkg::OFS_FAULT_ADDR:
            begin
                rd_data = cur_ff.fault_addr;
            end
            mfs_pkg::OFS_STACKED_PC:
            begin
                rd_data = cur_ff.stacked_pc;
            end
            mfs_pkg::OFS_CTRL:
            begin
                rd_data[mfs_pkg::BIT_MPU_EN] = cur_ff.mpu_en;
            end
            default:
            begin
                rd_data = mfs_pkg::RD_ZERO;         // Clear register, unmapped
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    // Coinciding faults: unstack first, then data, then fetch
    // Unstack wins so that its return frame stays untouched
    always_comb
    begin
        nxt_ff = cur_ff;
        // Single-cycle sequencer strobes default low
        nxt_ff.take = 1'b0;
        nxt_ff.chain = 1'b0;
        nxt_ff.skip_save = 1'b0;
        nxt_ff.sp_hold = 1'b0;
        nxt_ff.pc_we = 1'b0;

        // Software control writes
        // Enable register follows the status layout, per byte lane
        if (wr_en)
        begin
            nxt_ff.irq_en = (cur_ff.irq_en & ~wr_mask[7:0]) | wr_bits[7:0];
        end
        if (wr_ctrl && WB_SEL_I[0])
        begin
            nxt_ff.mpu_en = WB_DAT_I[mfs_pkg::BIT_MPU_EN];
        end

        // Unstack fault: chained entry on the untouched return frame
        // No PC push and no address load on this path
        if (UNSTACK_FAULT_I)
        begin
            nxt_ff.take = 1'b1;
            nxt_ff.chain = 1'b1;
            nxt_ff.skip_save = 1'b1;
            nxt_ff.sp_hold = 1'b1;
        end
        // Data fault: capture address, push faulting PC
        else if (DATA_FAULT_I)
        begin
            nxt_ff.take = 1'b1;
            nxt_ff.fault_addr = DATA_ADDR_I;
            nxt_ff.stacked_pc = FAULT_PC_I;
            nxt_ff.pc_we = 1'b1;
        end
        // Instruction fault: push faulting PC, address register kept
        // Fetch address is never written to the address register
        else if (instr_viol)
        begin
            nxt_ff.take = 1'b1;
            nxt_ff.stacked_pc = FAULT_PC_I;
            nxt_ff.pc_we = 1'b1;
        end

        // Level interrupt from enabled flags
        // One flop of lag behind the flags
        nxt_ff.irq = |(status & cur_ff.irq_en);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    // Reset branch loads constants only
    always_ff @(posedge MCLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            cur_ff.irq_en <= mfs_pkg::RST_IRQ_EN;
            cur_ff.mpu_en <= mfs_pkg::RST_MPU_EN;
            cur_ff.fault_addr <= mfs_pkg::RST_WORD;
            cur_ff.stacked_pc <= mfs_pkg::RST_WORD;
            cur_ff.take <= 1'b0;
            cur_ff.chain <= 1'b0;
            cur_ff.skip_save <= 1'b0;
            cur_ff.sp_hold <= 1'b0;
            cur_ff.pc_we <= 1'b0;
            cur_ff.irq <= 1'b0;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    // Strobes last one cycle; address holds until the next data fault, PC until the next data or fetch fault
    assign FAULT_TAKE_O = cur_ff.take;
    assign CHAIN_O = cur_ff.chain;
    assign SKIP_SAVE_O = cur_ff.skip_save;
    assign SP_HOLD_O = cur_ff.sp_hold;
    assign STACK_PC_WE_O = cur_ff.pc_we;
    assign STACK_PC_O = cur_ff.stacked_pc;
    assign MEM_FAULT_ADDRESS_REG_O = cur_ff.fault_addr;
    assign IRQ_O = cur_ff.irq;

endmodule

// *** bench/mfs_assertions.sv ***
// Port-level checker for the memory fault status block
`timescale 1ns/1ps

module mfs_assertions
(
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RESET_I,
    // Bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Fault inputs
    input wire logic UNSTACK_FAULT_I,
    input wire logic DATA_FAULT_I,
    input wire logic [31:0] DATA_ADDR_I,
    input wire logic FETCH_ISSUE_I,
    input wire logic EXECUTE_NEVER_ATTRIBUTE_I,
    input wire logic [31:0] FAULT_PC_I,
    // Sequencer and address outputs
    input wire logic FAULT_TAKE_O,
    input wire logic CHAIN_O,
    input wire logic SKIP_SAVE_O,
    input wire logic SP_HOLD_O,
    input wire logic STACK_PC_WE_O,
    input wire logic [31:0] STACK_PC_O,
    input wire logic [31:0] MEM_FAULT_ADDRESS_REG_O
);
    // One clock domain for every property
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);

    ////////////////////////////////////////////////////////////////////////////
    // Unstack fault chains with frame and stack pointer kept
    property p_unstack_seq;
        UNSTACK_FAULT_I |=> FAULT_TAKE_O && CHAIN_O && SKIP_SAVE_O && SP_HOLD_O && !STACK_PC_WE_O;
    endproperty
    a_unstack_seq: assert property (p_unstack_seq)
        else $error("unstack fault did not chain with save skipped");
    // Chain strobes only follow an unstack fault
    property p_chain_only;
        !UNSTACK_FAULT_I |=> !(CHAIN_O || SKIP_SAVE_O || SP_HOLD_O);
    endproperty
    a_chain_only: assert property (p_chain_only)
        else $error("chain strobe without unstack fault");
    // Only a data fault moves the fault address
    property p_addr_kept;
        !DATA_FAULT_I |=> $stable(MEM_FAULT_ADDRESS_REG_O);
    endproperty
    a_addr_kept: assert property (p_addr_kept)
        else $error("fault address changed without data fault");
    // Data fault captures the access address
    property p_data_addr;
        DATA_FAULT_I && !UNSTACK_FAULT_I |=> MEM_FAULT_ADDRESS_REG_O == $past(DATA_ADDR_I);
    endproperty
    a_data_addr: assert property (p_data_addr)
        else $error("data fault address not captured");
    // Pushed PC is the faulting instruction
    property p_pc_push;
        !UNSTACK_FAULT_I && (DATA_FAULT_I || FETCH_ISSUE_I && EXECUTE_NEVER_ATTRIBUTE_I)
        |=> STACK_PC_WE_O && STACK_PC_O == $past(FAULT_PC_I);
    endproperty
    a_pc_push: assert property (p_pc_push)
        else $error("stacked PC not the faulting one");
    // Execute-never fetch always faults
    property p_xn_take;
        FETCH_ISSUE_I && EXECUTE_NEVER_ATTRIBUTE_I |=> FAULT_TAKE_O;
    endproperty
    a_xn_take: assert property (p_xn_take)
        else $error("execute-never fetch did not fault");
    // No fault input, no handler entry
    property p_no_take;
        !(UNSTACK_FAULT_I || DATA_FAULT_I || FETCH_ISSUE_I) |=> !FAULT_TAKE_O && !STACK_PC_WE_O;
    endproperty
    a_no_take: assert property (p_no_take)
        else $error("fault entry without a fault");
    // Status reads show reserved bits as zero
    property p_rsvd_zero;
        WB_ACK_O && !WB_WE_I && WB_ADR_I == mfs_pkg::OFS_STATUS
        |-> WB_DAT_O[2] == 1'b0 && WB_DAT_O[6:4] == 3'h0 && WB_DAT_O[31:8] == 24'h000000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved status bit read nonzero");
    // Ack one cycle after the request, one cycle long
    property p_ack;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack timing wrong");
endmodule

bind mfs_top mfs_assertions u_chk
(
    .MCLK_I(MCLK_I), .RESET_I(RESET_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .UNSTACK_FAULT_I(UNSTACK_FAULT_I), .DATA_FAULT_I(DATA_FAULT_I),
    .DATA_ADDR_I(DATA_ADDR_I), .FETCH_ISSUE_I(FETCH_ISSUE_I),
    .EXECUTE_NEVER_ATTRIBUTE_I(EXECUTE_NEVER_ATTRIBUTE_I), .FAULT_PC_I(FAULT_PC_I),
    .FAULT_TAKE_O(FAULT_TAKE_O), .CHAIN_O(CHAIN_O), .SKIP_SAVE_O(SKIP_SAVE_O),
    .SP_HOLD_O(SP_HOLD_O), .STACK_PC_WE_O(STACK_PC_WE_O), .STACK_PC_O(STACK_PC_O),
    .MEM_FAULT_ADDRESS_REG_O(MEM_FAULT_ADDRESS_REG_O)
);

// *** bench/testbench.sv ***
// Self-checking bench for the memory fault status block
`timescale 1ns/1ps

module testbench;
    // Clock, reset, bus and fault stimulus
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, daddr = 32'h0, fpc = 32'h0, a1, p1, p2;
    logic unstk = 1'b0, dflt = 1'b0, fiss = 1'b0, xn = 1'b0, deny = 1'b0;
    // Design outputs
    logic [31:0] rdat, spc, faddr;
    logic ack, take, chain, skip, sph, pcwe, irq;
    // Expected read data and counters
    logic [31:0] expq [$];
    int n_fail = 0, cmp_count = 0, seed = 93516;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Device under test
    mfs_top dut
    (
        .MCLK_I(clk), .RESET_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .UNSTACK_FAULT_I(unstk), .DATA_FAULT_I(dflt), .DATA_ADDR_I(daddr),
        .FETCH_ISSUE_I(fiss), .EXECUTE_NEVER_ATTRIBUTE_I(xn), .FETCH_DENY_I(deny),
        .FAULT_PC_I(fpc), .FAULT_TAKE_O(take), .CHAIN_O(chain), .SKIP_SAVE_O(skip),
        .SP_HOLD_O(sph), .STACK_PC_WE_O(pcwe), .STACK_PC_O(spc),
        .MEM_FAULT_ADDRESS_REG_O(faddr), .IRQ_O(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Classic single bus cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (ack !== 1'b1)
            n_fail++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    // Read with expected value noted
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // One-cycle fault event: unstack, data, fetch with its qualifiers
    task automatic ev(input logic u, input logic d, input logic f, input logic x,
                      input logic n, input logic [31:0] a, input logic [31:0] p);
        @(posedge clk);
        unstk <= u;
        dflt <= d;
        fiss <= f;
        xn <= x;
        deny <= n;
        daddr <= a;
        fpc <= p;
        @(posedge clk);
        {unstk, dflt, fiss, xn, deny} <= 5'h00;
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Read answers checked against the oldest note
    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0)
        begin
            if (expq.size() == 0)
                chk(~rdat, rdat);
            else
                chk(expq.pop_front(), rdat);
        end
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        a1 = $random(seed);
        p1 = $random(seed);
        p2 = $random(seed);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped place
        rd(mfs_pkg::OFS_STATUS, 32'h0);
        rd(mfs_pkg::OFS_IRQ_EN, 32'h0);
        rd(mfs_pkg::OFS_IRQ_CLR, 32'h0);
        rd(8'h20, 32'h0);
        // Data fault captures address and PC
        ev(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, a1, p1);
        rd(mfs_pkg::OFS_STATUS, 32'h82);
        rd(mfs_pkg::OFS_FAULT_ADDR, a1);
        rd(mfs_pkg::OFS_STACKED_PC, p1);
        // Write zero keeps, write one clears, read-only address ignores writes
        bus(1'b1, mfs_pkg::OFS_STATUS, 32'h0);
        bus(1'b1, mfs_pkg::OFS_FAULT_ADDR, ~a1);
        rd(mfs_pkg::OFS_STATUS, 32'h82);
        bus(1'b1, mfs_pkg::OFS_STATUS, 32'h02);
        rd(mfs_pkg::OFS_STATUS, 32'h80);
        bus(1'b1, mfs_pkg::OFS_IRQ_CLR, 32'h80);
        rd(mfs_pkg::OFS_STATUS, 32'h0);
        // Execute-never fetch with protection off
        ev(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, ~a1, p2);
        rd(mfs_pkg::OFS_STATUS, 32'h01);
        rd(mfs_pkg::OFS_FAULT_ADDR, a1);
        rd(mfs_pkg::OFS_STACKED_PC, p2);
        bus(1'b1, mfs_pkg::OFS_IRQ_CLR, 32'h01);
        // Denied fetch faults only with protection on
        ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 32'h0, p1);
        rd(mfs_pkg::OFS_STATUS, 32'h0);
        bus(1'b1, mfs_pkg::OFS_CTRL, 32'h1);
        rd(mfs_pkg::OFS_CTRL, 32'h1);
        ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 32'h0, p2);
        rd(mfs_pkg::OFS_STATUS, 32'h01);
        bus(1'b1, mfs_pkg::OFS_STATUS, 32'h01);
        // Unstack fault keeps address and PC
        ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ~a1, p1);
        bus(1'b1, mfs_pkg::OFS_IRQ_CLR, 32'h04);
        rd(mfs_pkg::OFS_STATUS, 32'h08);
        rd(mfs_pkg::OFS_FAULT_ADDR, a1);
        rd(mfs_pkg::OFS_STACKED_PC, p2);
        // Interrupt masked, enabled, cleared
        @(negedge clk);
        chk(32'h0, {31'h0, irq});
        bus(1'b1, mfs_pkg::OFS_IRQ_EN, 32'h08);
        rd(mfs_pkg::OFS_IRQ_EN, 32'h08);
        @(negedge clk);
        chk(32'h1, {31'h0, irq});
        bus(1'b1, mfs_pkg::OFS_IRQ_CLR, 32'h08);
        repeat (2) @(negedge clk);
        chk(32'h0, {31'h0, irq});
        rd(mfs_pkg::OFS_STATUS, 32'h0);
        // Unstack and data fault together: no capture, no valid flag
        ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, ~a1, p1);
        rd(mfs_pkg::OFS_STATUS, 32'h0a);
        rd(mfs_pkg::OFS_FAULT_ADDR, a1);
        rd(mfs_pkg::OFS_STACKED_PC, p2);
        repeat (4) @(posedge clk);
        chk(32'h0, expq.size());
        close_out();
    end
endmodule
